// >>> hdl/fifo_pkg.sv
// shared constants and types of the dual-clock status-flag fifo
package fifo_pkg;

  // data path and storage geometry
  localparam int DATA_W = 72;
  localparam int DEPTH = 16384;
  localparam int ADDR_W = 14;
  localparam int PTR_W = 15;

  // pointer-width forms of the geometry
  localparam logic [PTR_W-1:0] DEPTH_P = 15'h4000;
  localparam logic [PTR_W-1:0] HALF_P = 15'h2000;
  localparam logic [PTR_W-1:0] ONE_P = 15'h0001;
  localparam logic [PTR_W-1:0] ZERO_P = 15'h0000;

  // flag offset width and the default offsets, indexed by {load, sel1, sel0}
  localparam int OFS_W = 14;
  localparam logic [OFS_W-1:0] OFFSET_TABLE [8] = '{
    14'h007f, // load low,  sel1 low,  sel0 low
    14'h00ff, // load low,  sel1 low,  sel0 high
    14'h01ff, // load low,  sel1 high, sel0 low
    14'h003f, // load low,  sel1 high, sel0 high
    14'h03ff, // load high, sel1 low,  sel0 low
    14'h000f, // load high, sel1 low,  sel0 high
    14'h001f, // load high, sel1 high, sel0 low
    14'h0007  // load high, sel1 high, sel0 high
  };

  // pin synchroniser count (one per pin) and positions of the control pins in the bundle
  localparam int SYNC_N = 9;
  localparam int P_WCLK = 8;
  localparam int P_RCLK = 7;
  localparam int P_WEN = 6;
  localparam int P_REN = 5;
  localparam int P_MRST = 4;
  localparam int P_FTS = 3;
  localparam int P_LD = 2;
  localparam int P_SEL1 = 1;
  localparam int P_SEL0 = 0;

  // status flags, all active low, travel together
  typedef struct packed {
    logic empty_flag_n;
    logic full_flag_n;
    logic output_ready_n;
    logic input_space_n;
    logic almost_empty_flag_n;
    logic almost_full_flag_n;
    logic half_full_flag_n;
  } status_flags_t;

  // flag values after reset and during master reset (standard mode view)
  localparam status_flags_t FLAGS_RESET = '{
    empty_flag_n: 1'b0, full_flag_n: 1'b1, output_ready_n: 1'b1,
    input_space_n: 1'b1, almost_empty_flag_n: 1'b0,
    almost_full_flag_n: 1'b1, half_full_flag_n: 1'b1
  };

  // read timing modes, one-hot
  typedef enum logic [1:0] {
    MODE_STANDARD = 2'b01,
    MODE_FALL_THROUGH = 2'b10
  } read_mode_t;

endpackage

// >>> hdl/dual_clock_fifo.sv
// dual-clock fifo core with standard and fall-through status flags
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none

module dual_clock_fifo (
  // system clock and reset
  input wire logic clk,
  input wire logic rst,
  // write port pins
  input wire logic wclk,
  input wire logic write_en_n,
  input wire logic [fifo_pkg::DATA_W-1:0] data_in,
  // read port pins
  input wire logic rclk,
  input wire logic read_en_n,
  output logic [fifo_pkg::DATA_W-1:0] read_data_out,
  // configuration pins
  input wire logic master_reset_n,
  input wire logic fall_through_select,
  input wire logic offset_load_select_n,
  input wire logic default_offset_sel0,
  input wire logic default_offset_sel1,
  // status flags
  output fifo_pkg::status_flags_t status
);
  import fifo_pkg::*;

  // gray code of a binary pointer
  // only one bit of a gray pointer moves per step, so a copy taken while
  // it changes is off by one word at most, never by a wild amount
  function automatic logic [PTR_W-1:0] to_gray(input logic [PTR_W-1:0] b);
    to_gray = b ^ (b >> 1);
  endfunction

  // binary value of a gray pointer
  function automatic logic [PTR_W-1:0] from_gray(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b = '0;
    b[PTR_W-1] = g[PTR_W-1];
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    from_gray = b;
  endfunction

  // pin synchronisers: three flops, a level counts once stages 2, 3 agree
  // the pins belong to no clock of ours, so the first stage may go
  // metastable; only stages 2 and 3 are read further on, and a filtered
  // level lags its pin by three to four cycles, which callers must allow
  logic [SYNC_N-1:0] pins;
  logic [SYNC_N-1:0] s1_q;
  logic [SYNC_N-1:0] s2_q;
  logic [SYNC_N-1:0] s3_q;
  logic [SYNC_N-1:0] lvl_q;

  assign pins = {wclk, rclk, write_en_n, read_en_n, master_reset_n,
                 fall_through_select, offset_load_select_n,
                 default_offset_sel1, default_offset_sel0};

  // one filtered synchroniser per control pin
  // a pin that glitches for one cycle never reaches the filtered level
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
          lvl_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= pins[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            lvl_q[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate

  // data bus follows the same three-stage delay as the write clock
  // so that the word taken at a write tick is the word that stood on the
  // pins around the write edge; a bus that settles after the write edge is missed
  logic [DATA_W-1:0] din1_q;
  logic [DATA_W-1:0] din2_q;
  logic [DATA_W-1:0] din3_q;

  // data bus delay line
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      din1_q <= '0;
      din2_q <= '0;
      din3_q <= '0;
    end else begin
      din1_q <= data_in;
      din2_q <= din1_q;
      din3_q <= din2_q;
    end
  end

  // link clock edges as one-cycle enables, and sampled control levels
  // a tick is the first cycle in which stages 2 and 3 both show the pin
  // high while the filtered level is still low, so each rising edge of a
  // link clock gives at most one tick however long the high phase lasts
  // enables are read from stage 3, aligned with the tick they qualify
  wire w_tick = s2_q[P_WCLK] & s3_q[P_WCLK] & ~lvl_q[P_WCLK];
  wire r_tick = s2_q[P_RCLK] & s3_q[P_RCLK] & ~lvl_q[P_RCLK];
  wire wen_lo = ~s3_q[P_WEN];
  wire ren_lo = ~s3_q[P_REN];
  wire mr = ~lvl_q[P_MRST];

  // configuration latched while master reset is held
  // mode and offsets keep following the pins until master reset ends, so
  // the values that stand at release are the ones that stay
  read_mode_t mode_q;
  logic [OFS_W-1:0] ofs_n_q;
  logic [OFS_W-1:0] ofs_m_q;

  wire [2:0] ofs_idx = {lvl_q[P_LD], lvl_q[P_SEL1], lvl_q[P_SEL0]};
  wire read_mode_t mode_d = lvl_q[P_FTS] ? MODE_FALL_THROUGH : MODE_STANDARD;
  wire fwft = (mode_q == MODE_FALL_THROUGH);

  // mode and default offsets follow the pins until master reset ends
  // n and m are loaded with the same default value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= MODE_STANDARD;
      ofs_n_q <= OFFSET_TABLE[0];
      ofs_m_q <= OFFSET_TABLE[0];
    end else if (mr) begin
      mode_q <= mode_d;
      ofs_n_q <= OFFSET_TABLE[ofs_idx];
      ofs_m_q <= OFFSET_TABLE[ofs_idx];
    end
  end

  // storage: one entry per word, never reset; a fresh fifo holds unknown
  // words until written, and the pointers keep them from being shown
  logic [DATA_W-1:0] mem [DEPTH];

  // write side: pointer, view of the read side, occupancy
  // the consumed pointer from the read side arrives two write ticks late,
  // so the write side overstates the count for a while; that only blocks
  // a write early, it never lets one overrun a word not yet read
  logic [PTR_W-1:0] wptr_q;
  logic [PTR_W-1:0] wgray_q;
  logic [PTR_W-1:0] cgray_w1_q;
  logic [PTR_W-1:0] cgray_w2_q;
  // consumed pointer in gray code, kept on the read side
  logic [PTR_W-1:0] cgray_q;

  // occupancy and thresholds; fall-through counts the word held in the
  // output register, so its capacity is one word more

  wire [PTR_W-1:0] cptr_w = from_gray(cgray_w2_q);
  wire [PTR_W-1:0] wcount = wptr_q - cptr_w;
  wire [PTR_W-1:0] cap = fwft ? (DEPTH_P + ONE_P) : DEPTH_P;
  wire [PTR_W-1:0] hf_lim = fwft ? (HALF_P + ONE_P) : HALF_P;
  wire [PTR_W-1:0] af_lim = cap - PTR_W'(ofs_m_q);
  wire wfull = (wcount >= cap);
  wire do_write = w_tick & wen_lo & ~mr & ~wfull;

  // store the word at the write pointer
  // a write is the only way an entry ever changes
  always_ff @(posedge clk) begin
    if (do_write) begin
      mem[wptr_q[ADDR_W-1:0]] <= din3_q;
    end
  end

  // write pointer and its gray image
  // master reset clears the pointer, so a reset fifo is empty at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wptr_q <= ZERO_P;
      wgray_q <= ZERO_P;
    end else if (mr) begin
      wptr_q <= ZERO_P;
      wgray_q <= ZERO_P;
    end else if (do_write) begin
      wptr_q <= wptr_q + ONE_P;
      wgray_q <= to_gray(wptr_q + ONE_P);
    end
  end

  // consumed-word pointer crosses to the write side on write edges
  // the read side publishes the consumed pointer, not the fetched one,
  // so the word held in the output register still counts as stored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cgray_w1_q <= ZERO_P;
      cgray_w2_q <= ZERO_P;
    end else if (mr) begin
      cgray_w1_q <= ZERO_P;
      cgray_w2_q <= ZERO_P;
    end else if (w_tick) begin
      cgray_w1_q <= cgray_q;
      cgray_w2_q <= cgray_w1_q;
    end
  end

  // read side: pointer, view of the write side, output register
  // the write pointer arrives two read ticks late, so a fresh word waits
  // for two read edges before it can be fetched; in fall-through the
  // third edge then loads it into the output register
  logic [PTR_W-1:0] rptr_q;
  logic [PTR_W-1:0] wgray_r1_q;
  logic [PTR_W-1:0] wgray_r2_q;
  logic out_valid_q;
  logic [DATA_W-1:0] dout_q;

  wire [PTR_W-1:0] wptr_r = from_gray(wgray_r2_q);
  wire [PTR_W-1:0] mcount = wptr_r - rptr_q;
  wire mem_has = (mcount != ZERO_P);
  // standard: a request moves data only when something is stored
  wire std_read = ~fwft & r_tick & ren_lo & ~mr & mem_has;
  // fall-through: refill the output register when it is free or taken
  wire ft_load = fwft & r_tick & ~mr & mem_has
                 & (~out_valid_q | ren_lo);
  wire ft_drain = fwft & r_tick & ~mr & out_valid_q & ren_lo
                  & ~mem_has;
  wire fetch = std_read | ft_load;
  wire [PTR_W-1:0] rptr_d = fetch ? (rptr_q + ONE_P) : rptr_q;
  wire out_valid_d = ft_load ? 1'b1 : (ft_drain ? 1'b0 : out_valid_q);
  // words handed to the reader; the word in the output register is not
  wire [PTR_W-1:0] cptr_d = rptr_d - PTR_W'(out_valid_d);
  // read-side count includes the word in the output register
  wire [PTR_W-1:0] rcount = wptr_r - (rptr_q - PTR_W'(out_valid_q));
  wire [PTR_W-1:0] ae_lim = fwft ? (PTR_W'(ofs_n_q) + ONE_P)
                                 : PTR_W'(ofs_n_q);

  // read pointer, output register state and consumed pointer
  // the read pointer counts fetched words; the consumed pointer lags it
  // by the word that waits in the output register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rptr_q <= ZERO_P;
      out_valid_q <= 1'b0;
      cgray_q <= ZERO_P;
    end else if (mr) begin
      rptr_q <= ZERO_P;
      out_valid_q <= 1'b0;
      cgray_q <= ZERO_P;
    end else begin
      rptr_q <= rptr_d;
      out_valid_q <= out_valid_d;
      cgray_q <= to_gray(cptr_d);
    end
  end

  // data outputs change only when a word is fetched or master reset clears them
  // in fall-through a fetch refills the output register; in standard it
  // is the requested word; an ignored read leaves the data alone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dout_q <= '0;
    end else if (mr) begin
      dout_q <= '0;
    end else if (fetch) begin
      dout_q <= mem[rptr_q[ADDR_W-1:0]];
    end
  end

  // write pointer crosses to the read side on read edges
  // two stages per crossing; the gray word has settled long before use
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wgray_r1_q <= ZERO_P;
      wgray_r2_q <= ZERO_P;
    end else if (mr) begin
      wgray_r1_q <= ZERO_P;
      wgray_r2_q <= ZERO_P;
    end else if (r_tick) begin
      wgray_r1_q <= wgray_q;
      wgray_r2_q <= wgray_r1_q;
    end
  end

  // status flags
  // every flag is judged from the occupancy seen on its own side and
  // registered once more; outside master reset the unused mode's flags sit high
  status_flags_t flags_d;
  status_flags_t flags_q;

  // flag values from the occupancy seen on each side
  // empty and full from the crossed pointers, output-ready from the
  // output register state
  assign flags_d.empty_flag_n = fwft | (mcount != ZERO_P);
  assign flags_d.full_flag_n = fwft | ~wfull;
  assign flags_d.output_ready_n = ~fwft | ~out_valid_d;
  assign flags_d.input_space_n = ~fwft | wfull;
  // read side: almost-empty against n, or n+1 in fall-through
  wire ae_over = (rcount > ae_lim);
  assign flags_d.almost_empty_flag_n = ae_over;
  // write side: half-full past half the depth, one later in fall-through
  wire hf_over = (wcount > hf_lim);
  assign flags_d.half_full_flag_n = ~hf_over;
  // write side: almost-full at capacity minus m
  wire af_reach = (wcount >= af_lim);
  assign flags_d.almost_full_flag_n = ~af_reach;

  // flag output register; master reset forces the reset view so that no
  // flag shows a stale count while the pointers are being cleared
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_q <= FLAGS_RESET;
    end else begin
      flags_q <= mr ? FLAGS_RESET : flags_d;
    end
  end

  // outputs come straight from registers
  assign status = flags_q;
  assign read_data_out = dout_q;

endmodule // dual_clock_fifo

`default_nettype wire

// >>> tb/fifo_properties.sv
// property checker for the dual-clock status-flag fifo
`timescale 1ns/100ps
`default_nettype none
module fifo_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins
  input wire logic wclk,
  input wire logic rclk,
  input wire logic master_reset_n,
  input wire logic fall_through_select,
  // outputs
  input wire logic [fifo_pkg::DATA_W-1:0] read_data_out,
  input wire fifo_pkg::status_flags_t status
);
  import fifo_pkg::*;
  logic [3:0] mr_q, wa_q, ra_q;
  logic ft_q, w1_q, r1_q;
  // settled mode, nearness to pin edges, idle and full views
  wire logic ok = mr_q == 4'hf;
  wire logic wnear = wa_q < 4'h9;
  wire logic rnear = ra_q < 4'h9;
  wire logic idle = ft_q ? status.output_ready_n : !status.empty_flag_n;
  wire logic full = ft_q ? status.input_space_n : !status.full_flag_n;
  wire logic [2:0] rf = {status.empty_flag_n, status.output_ready_n,
    status.almost_empty_flag_n};
  wire logic [3:0] wf = {status.full_flag_n, status.input_space_n,
    status.half_full_flag_n, status.almost_full_flag_n};
  // ages since master reset and pin rises, latched mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {mr_q, wa_q, ra_q, ft_q, w1_q, r1_q} <= '0;
    end else begin
      w1_q <= wclk;
      r1_q <= rclk;
      ft_q <= master_reset_n ? ft_q : fall_through_select;
      mr_q <= !master_reset_n ? 4'h0 : mr_q + 4'(!ok);
      wa_q <= (wclk && !w1_q) ? 4'h0 : wa_q + 4'(wa_q != 4'hf);
      ra_q <= (rclk && !r1_q) ? 4'h0 : ra_q + 4'(ra_q != 4'hf);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_MRESET_FLAGS: assert property (
    !master_reset_n [*8] |-> status == FLAGS_RESET)
    else $error("flags not at reset values");
  AST_UNUSED_HIGH: assert property (
    ok |-> (ft_q ? status.empty_flag_n && status.full_flag_n
      : status.output_ready_n && status.input_space_n))
    else $error("unused mode flags not high");
  AST_READ_CAUSE: assert property (
    ok |-> $stable(rf) || rnear)
    else $error("read side flag moved without read edge");
  AST_WRITE_CAUSE: assert property (
    ok |-> $stable(wf) || wnear)
    else $error("write side flag moved without write edge");
  AST_DATA_CAUSE: assert property (
    ok |-> $stable(read_data_out) || rnear)
    else $error("read data moved without read edge");
  AST_EMPTY_HOLDS: assert property (
    (ok && idle) [*8] |-> $stable(read_data_out))
    else $error("read data moved while empty");
  AST_EMPTY_AE: assert property (
    ok && idle |-> !status.almost_empty_flag_n)
    else $error("almost empty high while empty");
  AST_FULL_HF: assert property (
    ok |-> !full || !(status.half_full_flag_n || status.almost_full_flag_n))
    else $error("half or almost full high while full");
  // main scenarios
  cover property (ok && !ft_q && $rose(status.empty_flag_n));
  cover property (ok && ft_q && $fell(status.output_ready_n));
  cover property (ok && $rose(status.almost_empty_flag_n));
endmodule // fifo_properties
bind dual_clock_fifo fifo_properties u_props (.clk, .rst, .wclk, .rclk,
  .master_reset_n, .fall_through_select, .read_data_out, .status);
`default_nettype wire

// >>> tb/fifo_host_model.sv
// write-side and read-side host logic driving the fifo pins
`timescale 1ns/100ps
`default_nettype none
module fifo_host_model (
  // pacing clock
  input wire logic clk,
  // write side
  output logic wclk,
  output logic write_en_n,
  output logic [fifo_pkg::DATA_W-1:0] data_in,
  // read side
  output logic rclk,
  output logic read_en_n
);
  import fifo_pkg::*;
  // clocks stand low and enables off between transfers
  initial begin
    {wclk, rclk} = 2'b00;
    {write_en_n, read_en_n} = 2'b11;
    data_in = '0;
  end
  // one write clock period, word held around the rising edge
  task automatic write_word(input logic [DATA_W-1:0] d, input logic en);
    @(posedge clk);
    write_en_n <= !en;
    data_in <= d;
    repeat (3) @(posedge clk);
    wclk <= 1'b1;
    repeat (4) @(posedge clk);
    wclk <= 1'b0;
    write_en_n <= 1'b1;
    data_in <= ~d; // stale word not left on the lines
  endtask
  // one read clock period, enable held across the rising edge
  task automatic read_word(input logic en);
    @(posedge clk);
    read_en_n <= !en;
    repeat (3) @(posedge clk);
    rclk <= 1'b1;
    repeat (4) @(posedge clk);
    rclk <= 1'b0;
    read_en_n <= 1'b1;
  endtask
endmodule // fifo_host_model
`default_nettype wire

// >>> tb/dual_clock_fifo_tb.sv
// self-checking bench for the dual-clock status-flag fifo
`timescale 1ns/100ps
`default_nettype none
module dual_clock_fifo_tb;
  import fifo_pkg::*;
  logic clk, rst, wclk, write_en_n, rclk, read_en_n, master_reset_n;
  logic fall_through_select, offset_load_select_n;
  logic default_offset_sel0, default_offset_sel1;
  logic [DATA_W-1:0] data_in, read_data_out;
  status_flags_t status;
  int mismatches, n_checks, w, r;
  int ofs [8] = '{127, 255, 511, 63, 1023, 15, 31, 7};
  dual_clock_fifo dut (.clk(clk), .rst(rst), .wclk(wclk),
    .write_en_n(write_en_n), .data_in(data_in), .rclk(rclk),
    .read_en_n(read_en_n), .read_data_out(read_data_out),
    .master_reset_n(master_reset_n),
    .fall_through_select(fall_through_select),
    .offset_load_select_n(offset_load_select_n),
    .default_offset_sel0(default_offset_sel0),
    .default_offset_sel1(default_offset_sel1), .status(status));
  fifo_host_model host (.clk(clk), .wclk(wclk), .write_en_n(write_en_n),
    .data_in(data_in), .rclk(rclk), .read_en_n(read_en_n));
  // 20 MHz clock
  always #25 clk = ~clk;
  function automatic logic [DATA_W-1:0] word(input int k);
    return {8'h5a, 32'(k), ~32'(k)};
  endfunction
  // one flag bit
  task automatic chk_flag(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  // read data word
  task automatic chk_data(input logic [DATA_W-1:0] e);
    n_checks++;
    if (read_data_out !== e) begin
      mismatches++;
      $display("ERROR read_data_out expected %h seen %h", e, read_data_out);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // idle edges on both sides so pointers cross
  task automatic settle;
    repeat (2) begin
      host.write_word('0, 1'b0);
      host.read_word(1'b0);
    end
    repeat (4) @(posedge clk);
  endtask
  // master reset with mode and default offset code
  task automatic mreset(input logic ft, input logic [2:0] code);
    @(posedge clk);
    master_reset_n <= 1'b0;
    fall_through_select <= ft;
    {offset_load_select_n, default_offset_sel1, default_offset_sel0} <= code;
    settle;
    master_reset_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  // enabled read, then data compare
  task automatic rd(input logic [DATA_W-1:0] e);
    host.read_word(1'b1);
    repeat (4) @(posedge clk);
    chk_data(e);
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {master_reset_n, fall_through_select, offset_load_select_n,
      default_offset_sel1, default_offset_sel0} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // each default offset: almost-empty rises past n words
    for (int c = 0; c < 8; c++) begin
      mreset(1'b0, 3'(c));
      chk_flag("empty", 1'b0, status.empty_flag_n);
      for (w = 0; w < ofs[c]; w++) host.write_word(word(w), 1'b1);
      settle;
      chk_flag("empty", 1'b1, status.empty_flag_n);
      chk_flag("almost_empty", 1'b0, status.almost_empty_flag_n);
      host.write_word(word(w), 1'b1);
      settle;
      chk_flag("almost_empty", 1'b1, status.almost_empty_flag_n);
    end
    chk_flag("full", 1'b1, status.full_flag_n);
    chk_flag("half_full", 1'b1, status.half_full_flag_n);
    chk_flag("almost_full", 1'b1, status.almost_full_flag_n);
    // standard reads in order, down to empty, then an ignored read
    rd(word(0));
    settle;
    chk_flag("almost_empty", 1'b0, status.almost_empty_flag_n);
    for (r = 1; r < 8; r++) rd(word(r));
    settle;
    chk_flag("empty", 1'b0, status.empty_flag_n);
    rd(word(7));
    // fall-through: first word shows on the third read edge
    mreset(1'b1, 3'h7);
    chk_flag("input_space", 1'b0, status.input_space_n);
    host.write_word(word(20), 1'b1);
    repeat (2) host.read_word(1'b0);
    repeat (4) @(posedge clk);
    chk_flag("output_ready", 1'b1, status.output_ready_n);
    host.read_word(1'b0);
    repeat (4) @(posedge clk);
    chk_flag("output_ready", 1'b0, status.output_ready_n);
    chk_data(word(20));
    for (w = 21; w < 28; w++) host.write_word(word(w), 1'b1);
    settle;
    chk_flag("almost_empty", 1'b0, status.almost_empty_flag_n);
    host.write_word(word(28), 1'b1);
    settle;
    chk_flag("almost_empty", 1'b1, status.almost_empty_flag_n);
    rd(word(21));
    settle;
    chk_flag("almost_empty", 1'b0, status.almost_empty_flag_n);
    for (r = 22; r < 29; r++) rd(word(r));
    host.read_word(1'b1);
    settle;
    chk_flag("output_ready", 1'b1, status.output_ready_n);
    chk_flag("input_space", 1'b0, status.input_space_n);
    chk_flag("half_full", 1'b1, status.half_full_flag_n);
    chk_flag("almost_full", 1'b1, status.almost_full_flag_n);
    final_report;
  end
  // watchdog against a hang
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    final_report;
  end
endmodule // dual_clock_fifo_tb
`default_nettype wire
